// >>> logic/irq_ctrl_pkg.sv
// Constants, register map and types shared by the interrupt controller.
package irq_ctrl_pkg;

  localparam int NUM_REGS = 7;
  localparam int REG_W = 8;
  localparam int ADDR_W = 5;
  localparam int VEC_W = 13;
  localparam int DEPTH_W = 4;
  localparam int NUM_VECTORS = 11;
  localparam int NUM_PINS = 2;

  // Byte addresses of the registers on the bus, one aligned word each.
  localparam logic [ADDR_W-1:0] ADDR_EDGE_SELECT = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_PRIMARY_0 = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_PRIMARY_1 = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_PRIMARY_2 = 5'h0c;
  localparam logic [ADDR_W-1:0] ADDR_GROUP_0 = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_GROUP_1 = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_GROUP_2 = 5'h18;

  // Storage index of each register.
  localparam int IDX_EDGE = 0;
  localparam int IDX_PRI0 = 1;
  localparam int IDX_PRI1 = 2;
  localparam int IDX_PRI2 = 3;
  localparam int IDX_GRP0 = 4;
  localparam int IDX_GRP1 = 5;
  localparam int IDX_GRP2 = 6;

  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  // Implemented bits per register, index 6 first.
  localparam logic [NUM_REGS-1:0][REG_W-1:0] REG_MASK =
    {8'h33, 8'hff, 8'h33, 8'hff, 8'hff, 8'h7f, 8'h0f};
  // Request flag bits per register, index 6 first.
  localparam logic [NUM_REGS-1:0][REG_W-1:0] FLAG_MASK =
    {8'h30, 8'hf0, 8'h30, 8'hf0, 8'hf0, 8'h70, 8'h00};

  // Edge select field.
  localparam int EDGE_FIELD_W = 2;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Bit positions inside the control registers.
  localparam int GLOBAL_ENABLE_BIT = 0;
  localparam int PIN0_FLAG_BIT = 4;
  localparam int COMPARATOR_FLAG_BIT = 5;
  localparam int GROUP0_FLAG_BIT = 6;
  localparam int GROUP1_FLAG_BIT = 4;
  localparam int GROUP2_FLAG_BIT = 5;
  localparam int CONVERTER_FLAG_BIT = 6;
  localparam int TIMEBASE0_FLAG_BIT = 7;
  localparam int TIMEBASE1_FLAG_BIT = 4;
  localparam int PIN1_FLAG_BIT = 5;
  localparam int SERIAL_FLAG_BIT = 6;
  localparam int UART_FLAG_BIT = 7;
  localparam int STD_CMPP_FLAG_BIT = 4;
  localparam int STD_CMPA_FLAG_BIT = 5;
  localparam int PERIODIC_CMPP_FLAG_BIT = 4;
  localparam int PERIODIC_CMPA_FLAG_BIT = 5;
  localparam int COMPACT_CMPP_FLAG_BIT = 6;
  localparam int COMPACT_CMPA_FLAG_BIT = 7;
  localparam int LOW_VOLTAGE_FLAG_BIT = 4;
  localparam int EEPROM_FLAG_BIT = 5;

  // Vector table in priority order, index 0 has the lowest vector address.
  // Order: pin0, pin1, comparator, group0, group1, group2, converter,
  // timebase0, timebase1, serial module, uart.
  localparam int VEC_REG [NUM_VECTORS] = '{1, 3, 1, 1, 2, 2, 2, 2, 3, 3, 3};
  localparam int VEC_FLAG [NUM_VECTORS] = '{4, 5, 5, 6, 4, 5, 6, 7, 4, 6, 7};
  localparam int VEC_ENABLE [NUM_VECTORS] = '{1, 1, 2, 3, 0, 1, 2, 3, 0, 2, 3};
  localparam logic [VEC_W-1:0] VECTOR_BASE = 13'h0004;
  localparam logic [VEC_W-1:0] VECTOR_STEP = 13'h0004;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {
    ARB_IDLE,
    ARB_OFFER
  } arb_state_e;

endpackage : irq_ctrl_pkg

// >>> logic/irq_ctrl.sv
// Interrupt controller: edge select, flags, enables, arbitration, wake and AXI4-Lite registers.
// Operation
// - Pin 0 edge field bits 1:0: 00 off, 01 rise, 10 fall, 11 both.
// - Pin 1 edge field bits 3:2, same coding; bits 7:4 read zero.
// - A source's trigger sets its flag regardless of any enable.
// - A set flag causes a vector jump only when its enable is one.
// - Global enable at zero blocks every interrupt.
// - Taking an interrupt pushes the return address and loads the source vector.
// - Service routine ends with return, which pops the saved address.
// - Servicing an interrupt clears the global enable automatically.
// - Requests arriving during service still set and hold their flags.
// - A full stack holds every enabled request pending until it drains.
// - Simultaneous enabled requests are served one by one by fixed priority.
// - Any flag becoming set wakes the device, ungated by enables.
// - Primary register 0 layout: group0, comparator, pin0 flags and enables, global.
// - Primary register 1: timebase0, converter, group2, group1 flags then enables.
// - Primary register 2: uart, serial, pin1, timebase1 flags then enables.
// - Group register 0: standard timer compare flags 5:4, enables 1:0.
// - Group register 1: compact and periodic timer compare flags and enables.
// - Group register 2: eeprom flag 5, low voltage flag 4, enables 1:0.
// - All implemented bits read and write, reset to zero; others read zero.
// - A group flag sets when any of its source flags becomes set.
// - Serving a group clears the group flag but not its source flags.
// - Pin flags set on the selected edge; independent flags clear on service.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module irq_ctrl (
  input wire logic sysClk,
  input wire logic reset,
  // AXI4-Lite slave.
  input wire logic awvalid,
  output logic awready,
  input wire logic [irq_ctrl_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [irq_ctrl_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // External interrupt pins, asynchronous.
  input wire logic [irq_ctrl_pkg::NUM_PINS-1:0] extPin,
  // Peripheral request events, one-cycle pulses on sysClk.
  input wire logic comparatorEvent,
  input wire logic converterEvent,
  input wire logic timebase0Event,
  input wire logic timebase1Event,
  input wire logic serialModuleEvent,
  input wire logic uartEvent,
  input wire logic stdTimerCmpaEvent,
  input wire logic stdTimerCmppEvent,
  input wire logic compactTimerCmpaEvent,
  input wire logic compactTimerCmppEvent,
  input wire logic periodicTimerCmpaEvent,
  input wire logic periodicTimerCmppEvent,
  input wire logic lowVoltageEvent,
  input wire logic eepromEvent,
  // Program sequencer.
  input wire logic stackFull,
  output logic irqRequest,
  output logic [irq_ctrl_pkg::VEC_W-1:0] irqVector,
  input wire logic irqAck,
  input wire logic returnFromInterrupt,
  output logic inService,
  output logic wakeUp
);
  import irq_ctrl_pkg::*;

  typedef struct packed {
    logic [NUM_REGS-1:0][REG_W-1:0] regs;
    logic [NUM_PINS-1:0] pinSync1;
    logic [NUM_PINS-1:0] pinSync2;
    logic [NUM_PINS-1:0] pinPrev;
    logic awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [REG_W-1:0] wData;
    logic wLane0;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [REG_W-1:0] rData;
    logic [1:0] rResp;
    arb_state_e state;
    logic [3:0] sel;
    logic [VEC_W-1:0] vector;
    logic [DEPTH_W-1:0] depth;
    logic wake;
  } state_s;

  state_s state_q;
  state_s state_d;

  logic [NUM_REGS-1:0][REG_W-1:0] hwSet;
  logic [NUM_PINS-1:0] pinEdge;
  logic [NUM_VECTORS-1:0] pending;
  logic anyPending;
  logic [3:0] pick;
  logic globalEnable;
  logic offerValid;
  logic doWrite;
  logic writeHit;
  logic [2:0] writeIdx;
  logic readHit;
  logic [2:0] readIdx;
  logic groupRise0;
  logic groupRise1;
  logic groupRise2;

  function automatic logic [3:0] decodeAddr(input logic [ADDR_W-1:0] addr);
    logic [3:0] res;
    res = 4'h0;
    if (addr == ADDR_EDGE_SELECT) begin
      res = {1'b1, 3'(IDX_EDGE)};
    end else if (addr == ADDR_PRIMARY_0) begin
      res = {1'b1, 3'(IDX_PRI0)};
    end else if (addr == ADDR_PRIMARY_1) begin
      res = {1'b1, 3'(IDX_PRI1)};
    end else if (addr == ADDR_PRIMARY_2) begin
      res = {1'b1, 3'(IDX_PRI2)};
    end else if (addr == ADDR_GROUP_0) begin
      res = {1'b1, 3'(IDX_GRP0)};
    end else if (addr == ADDR_GROUP_1) begin
      res = {1'b1, 3'(IDX_GRP1)};
    end else if (addr == ADDR_GROUP_2) begin
      res = {1'b1, 3'(IDX_GRP2)};
    end
    return res;
  endfunction : decodeAddr

  assign globalEnable = state_q.regs[IDX_PRI0][GLOBAL_ENABLE_BIT];
  assign {writeHit, writeIdx} = decodeAddr(state_q.awAddr);
  assign {readHit, readIdx} = decodeAddr(araddr);
  assign doWrite = state_q.awHeld && state_q.wHeld && !state_q.bValid;

  // Only the second synchroniser stage and its delayed copy feed the edge detector.
  always_comb begin
    logic [1:0] mode;
    logic rise;
    logic fall;
    mode = EDGE_OFF;
    rise = 1'b0;
    fall = 1'b0;
    for (int i = 0; i < NUM_PINS; i++) begin
      mode = state_q.regs[IDX_EDGE][EDGE_FIELD_W*i +: EDGE_FIELD_W];
      rise = state_q.pinSync2[i] && !state_q.pinPrev[i];
      fall = !state_q.pinSync2[i] && state_q.pinPrev[i];
      pinEdge[i] = ((mode == EDGE_RISE) && rise) ||
                   ((mode == EDGE_FALL) && fall) ||
                   ((mode == EDGE_BOTH) && (rise || fall));
    end
  end

  // Hardware set requests, independent of any enable bit.
  always_comb begin
    hwSet = '0;
    hwSet[IDX_PRI0][PIN0_FLAG_BIT] = pinEdge[0];
    hwSet[IDX_PRI2][PIN1_FLAG_BIT] = pinEdge[1];
    hwSet[IDX_PRI0][COMPARATOR_FLAG_BIT] = comparatorEvent;
    hwSet[IDX_PRI1][CONVERTER_FLAG_BIT] = converterEvent;
    hwSet[IDX_PRI1][TIMEBASE0_FLAG_BIT] = timebase0Event;
    hwSet[IDX_PRI2][TIMEBASE1_FLAG_BIT] = timebase1Event;
    hwSet[IDX_PRI2][SERIAL_FLAG_BIT] = serialModuleEvent;
    hwSet[IDX_PRI2][UART_FLAG_BIT] = uartEvent;
    hwSet[IDX_GRP0][STD_CMPA_FLAG_BIT] = stdTimerCmpaEvent;
    hwSet[IDX_GRP0][STD_CMPP_FLAG_BIT] = stdTimerCmppEvent;
    hwSet[IDX_GRP1][COMPACT_CMPA_FLAG_BIT] = compactTimerCmpaEvent;
    hwSet[IDX_GRP1][COMPACT_CMPP_FLAG_BIT] = compactTimerCmppEvent;
    hwSet[IDX_GRP1][PERIODIC_CMPA_FLAG_BIT] = periodicTimerCmpaEvent;
    hwSet[IDX_GRP1][PERIODIC_CMPP_FLAG_BIT] = periodicTimerCmppEvent;
    hwSet[IDX_GRP2][EEPROM_FLAG_BIT] = eepromEvent;
    hwSet[IDX_GRP2][LOW_VOLTAGE_FLAG_BIT] = lowVoltageEvent;
  end

  // Fixed priority: scanning downward leaves the lowest vector index selected.
  always_comb begin
    pick = 4'h0;
    for (int v = 0; v < NUM_VECTORS; v++) begin
      pending[v] = state_q.regs[VEC_REG[v]][VEC_FLAG[v]] &&
                   state_q.regs[VEC_REG[v]][VEC_ENABLE[v]];
    end
    for (int v = NUM_VECTORS - 1; v >= 0; v--) begin
      if (pending[v]) begin
        pick = 4'(v);
      end
    end
  end

  assign anyPending = |pending;

  // The offer is withdrawn as soon as its flag, enable or the global enable drop,
  // or the stack fills, so the sequencer never acknowledges a stale request.
  assign offerValid = (state_q.state == ARB_OFFER) && pending[state_q.sel] &&
                      globalEnable && !stackFull;

  always_comb begin
    state_d = state_q;

    state_d.pinSync1 = extPin;
    state_d.pinSync2 = state_q.pinSync1;
    state_d.pinPrev = state_q.pinSync2;

    // Write channel: address and data may arrive in either order.
    if (awvalid && awready) begin
      state_d.awHeld = 1'b1;
      state_d.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      state_d.wHeld = 1'b1;
      state_d.wData = wdata[REG_W-1:0];
      state_d.wLane0 = wstrb[0];
    end
    if (doWrite) begin
      state_d.awHeld = 1'b0;
      state_d.wHeld = 1'b0;
      state_d.bValid = 1'b1;
      state_d.bResp = writeHit ? RESP_OKAY : RESP_SLVERR;
      if (writeHit && state_q.wLane0) begin
        state_d.regs[writeIdx] = state_q.wData & REG_MASK[writeIdx];
      end
    end
    if (state_q.bValid && bready) begin
      state_d.bValid = 1'b0;
    end

    // Read channel: one read in flight, answered one cycle after acceptance.
    if (arvalid && arready) begin
      state_d.rValid = 1'b1;
      state_d.rResp = readHit ? RESP_OKAY : RESP_SLVERR;
      state_d.rData = readHit ? (state_q.regs[readIdx] & REG_MASK[readIdx]) : '0;
    end else if (state_q.rValid && rready) begin
      state_d.rValid = 1'b0;
    end

    // Arbitration toward the program sequencer.
    case (state_q.state)
      ARB_IDLE: begin
        if (anyPending && globalEnable && !stackFull) begin
          state_d.sel = pick;
          state_d.vector = VECTOR_BASE + VEC_W'(VECTOR_STEP * pick);
          state_d.state = ARB_OFFER;
        end
      end
      ARB_OFFER: begin
        if (offerValid && irqAck) begin
          // Clearing after the software write lets the service clear win over it.
          state_d.regs[VEC_REG[state_q.sel]][VEC_FLAG[state_q.sel]] = 1'b0;
          state_d.regs[IDX_PRI0][GLOBAL_ENABLE_BIT] = 1'b0;
          state_d.state = ARB_IDLE;
        end else if (!offerValid) begin
          state_d.state = ARB_IDLE;
        end
      end
      default: begin
        state_d.state = ARB_IDLE;
      end
    endcase

    // Nesting depth; a software re-enable of the global bit allows depth above one.
    if (offerValid && irqAck && !(returnFromInterrupt && state_q.depth != '0)) begin
      state_d.depth = state_q.depth + DEPTH_W'(1);
    end else if (!(offerValid && irqAck) && returnFromInterrupt && state_q.depth != '0) begin
      state_d.depth = state_q.depth - DEPTH_W'(1);
    end

    // Hardware sets are applied last so they win over writes and service clears.
    state_d.regs = state_d.regs | hwSet;

    groupRise0 = |(state_d.regs[IDX_GRP0] & ~state_q.regs[IDX_GRP0] & FLAG_MASK[IDX_GRP0]);
    groupRise1 = |(state_d.regs[IDX_GRP1] & ~state_q.regs[IDX_GRP1] & FLAG_MASK[IDX_GRP1]);
    groupRise2 = |(state_d.regs[IDX_GRP2] & ~state_q.regs[IDX_GRP2] & FLAG_MASK[IDX_GRP2]);
    if (groupRise0) begin
      state_d.regs[IDX_PRI0][GROUP0_FLAG_BIT] = 1'b1;
    end
    if (groupRise1) begin
      state_d.regs[IDX_PRI1][GROUP1_FLAG_BIT] = 1'b1;
    end
    if (groupRise2) begin
      state_d.regs[IDX_PRI1][GROUP2_FLAG_BIT] = 1'b1;
    end

    // Only a 0-to-1 change wakes, so a flag preset before sleep stays silent.
    state_d.wake = 1'b0;
    for (int r = 0; r < NUM_REGS; r++) begin
      if (|(state_d.regs[r] & ~state_q.regs[r] & FLAG_MASK[r])) begin
        state_d.wake = 1'b1;
      end
    end
  end

  always_ff @(posedge sysClk) begin
    if (reset) begin
      state_q <= '0;
      state_q.state <= ARB_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign awready = !state_q.awHeld && !state_q.bValid;
  assign wready = !state_q.wHeld && !state_q.bValid;
  assign bvalid = state_q.bValid;
  assign bresp = state_q.bResp;
  assign arready = !state_q.rValid;
  assign rvalid = state_q.rValid;
  assign rdata = {24'h000000, state_q.rData};
  assign rresp = state_q.rResp;
  assign irqRequest = offerValid;
  assign irqVector = state_q.vector;
  assign inService = state_q.depth != '0;
  assign wakeUp = state_q.wake;

endmodule : irq_ctrl

`default_nettype wire

// >>> tb/irq_ctrl_props.sv
// Port-level concurrent checks for the interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_props (
  input wire logic sysClk,
  input wire logic reset,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  input wire logic stackFull,
  input wire logic irqRequest,
  input wire logic [irq_ctrl_pkg::VEC_W-1:0] irqVector,
  input wire logic irqAck,
  input wire logic returnFromInterrupt,
  input wire logic inService,
  input wire logic wakeUp
);
  import irq_ctrl_pkg::*;
  default clocking cb @(posedge sysClk); endclocking
  default disable iff (reset);
  full_blocks_req_a: assert property (stackFull |-> !irqRequest)
    else $error("request offered while stack full");
  ack_enters_svc_a: assert property (irqRequest && irqAck |=> (!irqRequest && inService) [*2])
    else $error("acknowledge did not enter service alone");
  vector_table_a: assert property (irqRequest |-> irqVector[1:0] == 2'h0
    && irqVector >= 13'h0004 && irqVector <= 13'h002c) else $error("vector outside table");
  offer_hold_a: assert property (irqRequest && !irqAck ##1 irqRequest |-> $stable(irqVector))
    else $error("vector changed during an offer");
  svc_holds_a: assert property (inService && !returnFromInterrupt |=> inService)
    else $error("service ended without return");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  rdata_zero_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  write_answer_a: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write response timing wrong");
  reset_clean_a: assert property ($fell(reset) |-> !inService && !irqRequest && !wakeUp)
    else $error("state not clear after reset");
endmodule : irq_ctrl_props
bind irq_ctrl irq_ctrl_props u_irq_ctrl_props (.sysClk, .reset, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .arvalid, .arready, .rvalid, .rdata, .stackFull, .irqRequest, .irqVector,
  .irqAck, .returnFromInterrupt, .inService, .wakeUp);
`default_nettype wire

// >>> tb/seq_model.sv
// Program sequencer model: acknowledges offers, pushes and pops a stack.
`timescale 1ns/1ps
`default_nettype none
module seq_model (
  input wire logic sysClk,
  input wire logic reset,
  input wire logic ackOn,
  input wire logic holdFull,
  input wire logic popReq,
  input wire logic irqRequest,
  input wire logic [irq_ctrl_pkg::VEC_W-1:0] irqVector,
  output logic irqAck,
  output logic stackFull,
  output logic returnFromInterrupt,
  output logic [irq_ctrl_pkg::VEC_W-1:0] lastVector,
  output var int ackCount
);
  import irq_ctrl_pkg::*;
  int depth;
  assign stackFull = holdFull;
  always_ff @(posedge sysClk) begin
    if (reset) begin
      irqAck <= 1'b0;
      returnFromInterrupt <= 1'b0;
      lastVector <= '0;
      ackCount <= 0;
      depth <= 0;
    end else begin
      // Ack is a single pulse so a later offer is never taken by a stale ack.
      irqAck <= ackOn && irqRequest && !irqAck;
      returnFromInterrupt <= popReq && depth != 0;
      if (irqRequest && irqAck) begin
        lastVector <= irqVector;
        ackCount <= ackCount + 1;
        depth <= depth + 1;
      end else if (returnFromInterrupt) begin
        depth <= depth - 1;
      end
    end
  end
endmodule : seq_model
`default_nettype wire

// >>> tb/tb_irq_ctrl.sv
// Self-checking bench for the interrupt controller with a sequencer model.
`timescale 1ns/1ps
`default_nettype none
module tb_irq_ctrl;
  import irq_ctrl_pkg::*;
  logic sysClk = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b1, rready = 1'b1, ackOn = 1'b0, holdFull = 1'b0, popReq = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'h1;
  logic [1:0] bresp, rresp, rs;
  logic awready, wready, bvalid, arready, rvalid, stackFull, irqRequest, irqAck;
  logic returnFromInterrupt, inService, wakeUp;
  logic [NUM_PINS-1:0] extPin = '0;
  logic [13:0] ev = '0;
  logic [VEC_W-1:0] irqVector, lastVector;
  logic [7:0] rd;
  int ackCount, miscompares = 0, comparisons = 0, cycles = 0, wakeCount = 0, seen = 0;
  irq_ctrl u_irq_ctrl (.sysClk, .reset, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .extPin, .comparatorEvent(ev[0]), .converterEvent(ev[1]), .timebase0Event(ev[2]),
    .timebase1Event(ev[3]), .serialModuleEvent(ev[4]), .uartEvent(ev[5]),
    .stdTimerCmpaEvent(ev[6]), .stdTimerCmppEvent(ev[7]), .compactTimerCmpaEvent(ev[8]),
    .compactTimerCmppEvent(ev[9]), .periodicTimerCmpaEvent(ev[10]),
    .periodicTimerCmppEvent(ev[11]), .lowVoltageEvent(ev[12]), .eepromEvent(ev[13]),
    .stackFull, .irqRequest, .irqVector, .irqAck, .returnFromInterrupt, .inService, .wakeUp);
  seq_model u_seq_model (.sysClk, .reset, .ackOn, .holdFull, .popReq, .irqRequest, .irqVector,
    .irqAck, .stackFull, .returnFromInterrupt, .lastVector, .ackCount);
  initial forever #12.5 sysClk = ~sysClk;
  always @(posedge sysClk) begin
    cycles <= cycles + 1;
    if (wakeUp === 1'b1) wakeCount <= wakeCount + 1;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : checkVal
  task automatic tick(input int n);
    repeat (n) @(posedge sysClk);
  endtask : tick
  task automatic pulse(input logic [13:0] m);
    ev <= m;
    tick(1);
    ev <= '0;
    tick(1);
  endtask : pulse
  task automatic axiWrite(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= 32'(d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge sysClk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
  endtask : axiWrite
  task automatic expReg(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge sysClk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge sysClk); while (!rvalid);
    checkVal(32'(rdata[7:0]), 32'(e));
    checkVal(32'(rresp), 32'(r));
  endtask : expReg
  // Waits for the next acknowledge, then judges the vector that was taken.
  task automatic expAck(input int idx);
    for (int i = 0; i < 60 && ackCount == seen; i++) @(posedge sysClk);
    // A missing acknowledge must fail here, not leave a stale vector to be judged.
    checkVal(32'(ackCount - seen), 1);
    seen = ackCount;
    checkVal(32'(lastVector), 32'(VECTOR_BASE + VECTOR_STEP * idx));
  endtask : expAck
  task automatic ret();
    popReq <= 1'b1;
    tick(1);
    popReq <= 1'b0;
    tick(3);
  endtask : ret
  task automatic t_reset();
    for (int i = 0; i < NUM_REGS; i++) expReg(ADDR_W'(4 * i), 8'h00, RESP_OKAY);
    expReg(5'h1c, 8'h00, RESP_SLVERR);
    axiWrite(5'h1c, 8'hff);
    checkVal(32'(rs), 32'(RESP_SLVERR));
    // With the low byte lane off the write is answered but changes nothing.
    wstrb <= 4'h0;
    axiWrite(ADDR_EDGE_SELECT, 8'h0f);
    wstrb <= 4'h1;
    checkVal(32'(rs), 32'(RESP_OKAY));
    expReg(ADDR_EDGE_SELECT, 8'h00, RESP_OKAY);
  endtask : t_reset
  task automatic t_regs();
    for (int i = 0; i < NUM_REGS; i++) begin
      axiWrite(ADDR_W'(4 * i), 8'hff);
      expReg(ADDR_W'(4 * i), REG_MASK[i], RESP_OKAY);
    end
    for (int i = 0; i < NUM_REGS; i++) begin
      axiWrite(ADDR_W'(4 * i), 8'h00);
      expReg(ADDR_W'(4 * i), 8'h00, RESP_OKAY);
    end
  endtask : t_regs
  task automatic t_gate();
    int w;
    w = wakeCount;
    ackOn <= 1'b1;
    pulse(14'h0001);
    tick(2);
    checkVal(wakeCount - w, 1);
    expReg(ADDR_PRIMARY_0, 8'h20, RESP_OKAY);
    pulse(14'h0001);
    tick(2);
    checkVal(wakeCount - w, 1);
    axiWrite(ADDR_PRIMARY_0, 8'h24);
    tick(4);
    checkVal(32'(irqRequest), 0);
    holdFull <= 1'b1;
    axiWrite(ADDR_PRIMARY_0, 8'h25);
    tick(4);
    checkVal(32'(irqRequest), 0);
    holdFull <= 1'b0;
    expAck(2);
    expReg(ADDR_PRIMARY_0, 8'h04, RESP_OKAY);
    pulse(14'h0001);
    expReg(ADDR_PRIMARY_0, 8'h24, RESP_OKAY);
    checkVal(32'(inService), 1);
    ret();
    checkVal(32'(inService), 0);
    // The event is sampled at the very edge at which the clearing write lands.
    fork
      axiWrite(ADDR_PRIMARY_0, 8'h00);
      begin
        tick(1);
        ev <= 14'h0001;
        tick(1);
        ev <= '0;
      end
    join
    expReg(ADDR_PRIMARY_0, 8'h20, RESP_OKAY);
    axiWrite(ADDR_PRIMARY_0, 8'h00);
  endtask : t_gate
  task automatic t_group();
    pulse(14'h3fd8);
    expReg(ADDR_GROUP_0, 8'h30, RESP_OKAY);
    expReg(ADDR_GROUP_1, 8'hf0, RESP_OKAY);
    expReg(ADDR_GROUP_2, 8'h30, RESP_OKAY);
    expReg(ADDR_PRIMARY_0, 8'h40, RESP_OKAY);
    expReg(ADDR_PRIMARY_1, 8'h30, RESP_OKAY);
    expReg(ADDR_PRIMARY_2, 8'h50, RESP_OKAY);
    for (int i = 1; i < NUM_REGS; i++) axiWrite(ADDR_W'(4 * i), 8'h00);
    axiWrite(ADDR_GROUP_2, 8'h10);
    expReg(ADDR_PRIMARY_1, 8'h20, RESP_OKAY);
    axiWrite(ADDR_PRIMARY_1, 8'h22);
    axiWrite(ADDR_PRIMARY_0, 8'h01);
    expAck(5);
    expReg(ADDR_PRIMARY_1, 8'h02, RESP_OKAY);
    expReg(ADDR_GROUP_2, 8'h10, RESP_OKAY);
    ret();
    axiWrite(ADDR_PRIMARY_1, 8'h00);
    axiWrite(ADDR_GROUP_2, 8'h00);
  endtask : t_group
  task automatic t_prio();
    int order [3] = '{6, 7, 10};
    axiWrite(ADDR_PRIMARY_1, 8'h0c);
    axiWrite(ADDR_PRIMARY_2, 8'h08);
    pulse(14'h0026);
    for (int k = 0; k < 3; k++) begin
      axiWrite(ADDR_PRIMARY_0, 8'h01);
      expAck(order[k]);
      ret();
    end
    expReg(ADDR_PRIMARY_1, 8'h0c, RESP_OKAY);
    expReg(ADDR_PRIMARY_2, 8'h08, RESP_OKAY);
    axiWrite(ADDR_PRIMARY_1, 8'h00);
    axiWrite(ADDR_PRIMARY_2, 8'h00);
  endtask : t_prio
  task automatic t_pins();
    for (int m = 0; m < 4; m++) begin
      axiWrite(ADDR_EDGE_SELECT, 8'(m));
      extPin <= 2'b01;
      tick(6);
      expReg(ADDR_PRIMARY_0, {3'h0, m[0], 4'h0}, RESP_OKAY);
      axiWrite(ADDR_PRIMARY_0, 8'h00);
      extPin <= 2'b00;
      tick(6);
      expReg(ADDR_PRIMARY_0, {3'h0, m[1], 4'h0}, RESP_OKAY);
      axiWrite(ADDR_PRIMARY_0, 8'h00);
    end
    axiWrite(ADDR_EDGE_SELECT, 8'h08);
    extPin <= 2'b10;
    tick(6);
    expReg(ADDR_PRIMARY_2, 8'h00, RESP_OKAY);
    extPin <= 2'b00;
    tick(6);
    expReg(ADDR_PRIMARY_2, 8'h20, RESP_OKAY);
  endtask : t_pins
  initial begin
    tick(2);
    reset <= 1'b0;
    tick(1);
    t_reset();
    t_regs();
    t_gate();
    t_group();
    t_prio();
    t_pins();
    wrap_up();
  end
endmodule : tb_irq_ctrl
`default_nettype wire
